/* core/bmsc_top.sv */
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
module bmsc_top import bmsc_pkg::*; #(
  parameter int OCP_CYC = OCP_CYCLES,
  parameter int SETTLE_CYC = SETTLE_CYCLES,
  parameter int SLOT_CYC = SLOT_CYCLES,
  parameter int DVS_CYC = DVS_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port.
  input wire logic [ADR_W-1:0] reg_addr_in,
  input wire logic [DAT_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DAT_W-1:0] reg_rdata_out,
  // Host pins.
  input wire logic standby_in,
  input wire logic power_button_input_in,
  // Analog monitors.
  input wire logic main_supply_low_in,
  input wire logic [NUM_BUCK-1:0] overcurrent_in,
  input wire logic [NUM_BUCK-1:0] in_regulation_in,
  // Power stage control.
  output bmsc_stage_type [NUM_BUCK-1:0] stage_out,
  output bmsc_pstate_type pstate_out,
  output logic irq_out
);
  localparam int SYN_W = 3 + 2 * NUM_BUCK;
  localparam int DVS_W = $clog2(DVS_CYC + 1);
  localparam int SLOT_W = $clog2(SLOT_CYC + 1);

  // Pin synchronisers.
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      syn1_q <= '0;
      syn2_q <= '0;
    end else begin
      syn1_q <= {in_regulation_in, overcurrent_in, main_supply_low_in, power_button_input_in, standby_in};
      syn2_q <= syn1_q;
    end
  end

  wire logic stby_s = syn2_q[0];
  wire logic btn_s = syn2_q[1];
  wire logic uv_s = syn2_q[2];
  wire logic [NUM_BUCK-1:0] oc_s = syn2_q[3 +: NUM_BUCK];
  wire logic [NUM_BUCK-1:0] reg_s = syn2_q[3 + NUM_BUCK +: NUM_BUCK];

  logic btn_prev_q;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      btn_prev_q <= 1'b0;
    end else begin
      btn_prev_q <= btn_s;
    end
  end

  // Register state.
  logic [DAT_W-1:0] ctrl_q;
  logic [ST_W-1:0] st_q;
  logic [ST_W-1:0] mask_q;
  logic [DAT_W-1:0] cfg_q [NUM_BUCK];
  logic [SP_W-1:0] nrm_q [NUM_BUCK];
  logic [SP_W-1:0] stb_q [NUM_BUCK];
  logic [SP_W-1:0] slp_q [NUM_BUCK];
  logic [DAT_W-1:0] rdata_q;
  logic irq_q;

  // Regulator state.
  bmsc_stage_type stage_q [NUM_BUCK];
  bmsc_ss_type ss_q [NUM_BUCK];
  logic [SP_W-1:0] cur_q [NUM_BUCK];
  logic [NUM_BUCK-1:0] pend_q;
  logic [NUM_BUCK-1:0] keep_v;
  logic [NUM_BUCK-1:0] ocp_done;

  // Power state and sequencing.
  bmsc_pstate_type ps_q;
  bmsc_pstate_type ps_d;
  logic [DVS_W-1:0] dvs_cnt_q;
  logic [SLOT_W-1:0] slot_cnt_q;
  logic [CFG_SLOT_W-1:0] seq_q;

  // Bus decode.
  wire logic wr_ctrl = reg_wr_in && (reg_addr_in == A_CTRL);
  wire logic wr_status = reg_wr_in && (reg_addr_in == A_STATUS);
  wire logic wr_mask = reg_wr_in && (reg_addr_in == A_MASK);
  wire logic style = ctrl_q[CTRL_STYLE_BIT];

  // Events.
  wire logic btn_fall = btn_prev_q && !btn_s;
  wire logic ton_ev = !uv_s && (style ? btn_fall : btn_s);
  wire logic toff_ev = !style && !btn_s;
  wire logic any_keep = |keep_v;
  wire logic dvs_tick = dvs_cnt_q == DVS_W'(DVS_CYC - 1);
  wire logic slot_tick = slot_cnt_q == SLOT_W'(SLOT_CYC - 1);
  wire logic in_on = (ps_q == PS_ON) || (ps_q == PS_STBY);
  wire logic from_off = ps_q == PS_OFF;
  wire logic seq_start = (from_off || (ps_q == PS_SLEEP)) && (ps_d == PS_ON);
  wire logic coin_entry = (ps_d == PS_COIN) && (ps_q != PS_COIN);
  wire logic going_off = (ps_d == PS_OFF) || (ps_d == PS_COIN);
  wire logic going_sleep = ps_d == PS_SLEEP;

  always_comb begin
    ps_d = ps_q;
    unique case (ps_q)
      PS_OFF: begin
        if (uv_s) begin
          ps_d = PS_COIN;
        end else if (ton_ev) begin
          ps_d = PS_ON;
        end
      end
      PS_COIN: begin
        if (!uv_s) begin
          ps_d = PS_OFF;
        end
      end
      PS_ON: begin
        if (uv_s) begin
          ps_d = PS_COIN;
        end else if (toff_ev) begin
          ps_d = any_keep ? PS_SLEEP : PS_OFF;
        end else if (stby_s) begin
          ps_d = PS_STBY;
        end
      end
      PS_STBY: begin
        if (uv_s) begin
          ps_d = PS_COIN;
        end else if (toff_ev) begin
          ps_d = any_keep ? PS_SLEEP : PS_OFF;
        end else if (!stby_s) begin
          ps_d = PS_ON;
        end
      end
      PS_SLEEP: begin
        if (uv_s) begin
          ps_d = PS_COIN;
        end else if (ton_ev) begin
          ps_d = PS_ON;
        end
      end
      default: ps_d = PS_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ps_q <= PS_OFF;
    end else begin
      ps_q <= ps_d;
    end
  end

  // Shared stepper and slot timers.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || dvs_tick) begin
      dvs_cnt_q <= '0;
    end else begin
      dvs_cnt_q <= dvs_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || seq_start || !in_on || slot_tick) begin
      slot_cnt_q <= '0;
    end else begin
      slot_cnt_q <= slot_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || seq_start) begin
      seq_q <= '0;
    end else if (in_on && slot_tick && (seq_q != SEQ_MAX)) begin
      seq_q <= seq_q + 1'b1;
    end
  end

  // Per-regulator control.
  for (genvar i = 0; i < NUM_BUCK; i++) begin : g_ch
    localparam logic [SP_W-1:0] MASK = (i == 0) ? FIRST_SP_MASK : SP_MASK;
    wire logic wr_cfg = reg_wr_in && (reg_addr_in == A_CFG + ADR_W'(i));
    wire logic wr_nrm = reg_wr_in && (reg_addr_in == A_NRM + ADR_W'(i));
    wire logic wr_stb = reg_wr_in && (reg_addr_in == A_STB + ADR_W'(i));
    wire logic wr_slp = reg_wr_in && (reg_addr_in == A_SLP + ADR_W'(i));
    wire logic keep = cfg_q[i][CFG_KEEP_BIT];
    wire logic [CFG_SLOT_W-1:0] slot = cfg_q[i][CFG_SLOT_LSB +: CFG_SLOT_W];
    wire bmsc_pair_type pair = bmsc_decode(cfg_q[i][CFG_MODE_LSB +: CFG_MODE_W]);
    wire logic drop = going_off || (going_sleep && !keep);
    wire logic restart = seq_start && (from_off || !keep);
    wire logic reload = seq_start && !from_off && !keep;
    wire logic launch = pend_q[i] && in_on && (seq_q >= slot) && (ss_q[i] == SS_IDLE);
    wire logic settle_done;
    wire logic on_d;
    bmsc_ss_type ss_d;
    bmsc_sw_type run_mode;
    bmsc_sw_type mode_d;
    logic [SP_W-1:0] target;

    assign keep_v[i] = keep;

    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        cfg_q[i] <= CFG_RST;
        nrm_q[i] <= NRM_RST;
        stb_q[i] <= STB_RST;
        slp_q[i] <= SLP_RST;
      end else begin
        if (reload) begin
          cfg_q[i][CFG_MODE_LSB +: CFG_MODE_W] <= CFG_RST[CFG_MODE_LSB +: CFG_MODE_W];
          nrm_q[i] <= NRM_RST;
        end
        if (wr_cfg) begin
          cfg_q[i] <= reg_wdata_in;
        end
        if (wr_nrm) begin
          nrm_q[i] <= reg_wdata_in[SP_W-1:0] & MASK;
        end
        if (wr_stb) begin
          stb_q[i] <= reg_wdata_in[SP_W-1:0] & MASK;
        end
        if (wr_slp) begin
          slp_q[i] <= reg_wdata_in[SP_W-1:0] & MASK;
        end
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        pend_q[i] <= 1'b0;
      end else if (restart) begin
        pend_q[i] <= 1'b1;
      end else if (drop || launch) begin
        pend_q[i] <= 1'b0;
      end
    end

    always_comb begin
      ss_d = ss_q[i];
      unique case (ss_q[i])
        SS_IDLE: ss_d = launch ? SS_PFM : SS_IDLE;
        SS_PFM: ss_d = dvs_tick ? SS_APS : SS_PFM;
        SS_APS: ss_d = dvs_tick ? SS_PWM : SS_APS;
        SS_PWM: ss_d = reg_s[i] ? SS_SETTLE : SS_PWM;
        SS_SETTLE: ss_d = settle_done ? SS_RUN : SS_SETTLE;
        SS_RUN: ss_d = SS_RUN;
        default: ss_d = SS_IDLE;
      endcase
      if (drop) begin
        ss_d = SS_IDLE;
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        ss_q[i] <= SS_IDLE;
      end else begin
        ss_q[i] <= ss_d;
      end
    end

    bmsc_timer #(
      .CYCLES(SETTLE_CYC)
    ) u_settle (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .run_in(ss_q[i] == SS_SETTLE),
      .done_out(settle_done)
    );

    bmsc_timer #(
      .CYCLES(OCP_CYC)
    ) u_ocp (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .run_in(oc_s[i] && stage_q[i].enable),
      .done_out(ocp_done[i])
    );

    always_comb begin
      if (ps_q == PS_SLEEP) begin
        run_mode = SW_PFM;
        target = slp_q[i] & MASK;
      end else if (ps_q == PS_STBY) begin
        run_mode = pair.stb;
        target = stb_q[i] & MASK;
      end else begin
        run_mode = pair.nrm;
        target = nrm_q[i] & MASK;
      end
      unique case (ss_q[i])
        SS_PFM: mode_d = SW_PFM;
        SS_APS: mode_d = SW_APS;
        SS_PWM, SS_SETTLE: mode_d = SW_PWM;
        SS_RUN: mode_d = run_mode;
        default: mode_d = SW_OFF;
      endcase
    end

    assign on_d = mode_d != SW_OFF;

    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        cur_q[i] <= NRM_RST & MASK;
      end else if (!on_d) begin
        cur_q[i] <= target;
      end else if (dvs_tick && (cur_q[i] < target)) begin
        cur_q[i] <= cur_q[i] + 1'b1;
      end else if (dvs_tick && (cur_q[i] > target)) begin
        cur_q[i] <= cur_q[i] - 1'b1;
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        stage_q[i] <= '{1'b0, 1'b1, 1'b0, SW_OFF, NRM_RST & MASK};
      end else begin
        stage_q[i].enable <= on_d;
        stage_q[i].discharge <= !on_d;
        stage_q[i].limit <= oc_s[i] && on_d;
        stage_q[i].mode <= mode_d;
        stage_q[i].setpoint <= cur_q[i];
      end
    end

    assign stage_out[i] = stage_q[i];
  end

  // Status, mask and interrupt.
  wire logic [ST_W-1:0] st_set = {seq_start, coin_entry, ocp_done};
  wire logic [ST_W-1:0] st_clr = wr_status ? reg_wdata_in[ST_W-1:0] : '0;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctrl_q <= '0;
      st_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_in;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata_in[ST_W-1:0];
      end
      st_q <= (st_q & ~st_clr) | st_set;
      irq_q <= |(st_q & mask_q);
    end
  end

  // Read path.
  logic [DAT_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (reg_addr_in == A_CTRL) begin
      rd_mux = ctrl_q;
    end
    if (reg_addr_in == A_STATUS) begin
      rd_mux = DAT_W'(st_q);
    end
    if (reg_addr_in == A_MASK) begin
      rd_mux = DAT_W'(mask_q);
    end
    if (reg_addr_in == A_PSTATE) begin
      rd_mux = DAT_W'(ps_q);
    end
    for (int i = 0; i < NUM_BUCK; i++) begin
      if (reg_addr_in == A_CFG + ADR_W'(i)) begin
        rd_mux = cfg_q[i];
      end
      if (reg_addr_in == A_NRM + ADR_W'(i)) begin
        rd_mux = DAT_W'(nrm_q[i]);
      end
      if (reg_addr_in == A_STB + ADR_W'(i)) begin
        rd_mux = DAT_W'(stb_q[i]);
      end
      if (reg_addr_in == A_SLP + ADR_W'(i)) begin
        rd_mux = DAT_W'(slp_q[i]);
      end
      if (reg_addr_in == A_LIVE + ADR_W'(i)) begin
        rd_mux = DAT_W'({ss_q[i] == SS_RUN, stage_q[i].limit, stage_q[i].discharge,
                         stage_q[i].enable, stage_q[i].mode});
      end
      if (reg_addr_in == A_CUR + ADR_W'(i)) begin
        rd_mux = DAT_W'(stage_q[i].setpoint);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : '0;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign pstate_out = ps_q;
  assign irq_out = irq_q;
endmodule : bmsc_top

/* core/bmsc_pkg.sv */
// Function
// - Supply undervoltage moves state to coin cell.
// - Overcurrent over 8 ms raises fault interrupt.
// - Soft-start steps PFM, APS, then PWM.
// - 3 ms after regulation, apply programmed mode.
// - Mode code selects Normal and Standby modes.
// - Off mode stops switching and discharges output.
// - Mode changes on writes and state changes.
// - Standby uses standby set point and mode.
// - Leaving Standby restores normal mode and voltage.
// - Set point changes step through the stepper.
// - Normal and standby set points share encoding.
// - Turn-off: kept regulators sleep, others off.
// - Sleep uses sleep set point and PFM.
// - Kept regulators stay on leaving Sleep.
// - Others restart at their slot with defaults.
// - Sleep set point six or seven bits.
// - Standby pin selects standby set point.
// - Level mode: low button is turn-off.
package bmsc_pkg;
  localparam int NUM_BUCK = 3;
  localparam int SP_W = 7;
  localparam int DAT_W = 8;
  localparam int ADR_W = 5;
  localparam logic [SP_W-1:0] FIRST_SP_MASK = 7'h3F;
  localparam logic [SP_W-1:0] SP_MASK = 7'h7F;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OCP_TIME_US = 8000;
  localparam int SETTLE_TIME_US = 3000;
  localparam int SLOT_TIME_US = 2000;
  localparam int DVS_STEP_NS = 4000;
  localparam int OCP_CYCLES = (OCP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SLOT_CYCLES = SLOT_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int DVS_CYCLES = DVS_STEP_NS / CLK_PERIOD_NS;
  localparam logic [ADR_W-1:0] A_CTRL = 5'h00;
  localparam logic [ADR_W-1:0] A_STATUS = 5'h01;
  localparam logic [ADR_W-1:0] A_MASK = 5'h02;
  localparam logic [ADR_W-1:0] A_PSTATE = 5'h03;
  localparam logic [ADR_W-1:0] A_CFG = 5'h04;
  localparam logic [ADR_W-1:0] A_NRM = 5'h07;
  localparam logic [ADR_W-1:0] A_STB = 5'h0A;
  localparam logic [ADR_W-1:0] A_SLP = 5'h0D;
  localparam logic [ADR_W-1:0] A_LIVE = 5'h10;
  localparam logic [ADR_W-1:0] A_CUR = 5'h13;
  localparam int CTRL_STYLE_BIT = 0;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_W = 4;
  localparam int CFG_KEEP_BIT = 4;
  localparam int CFG_SLOT_LSB = 5;
  localparam int CFG_SLOT_W = 3;
  localparam int ST_OCP_LSB = 0;
  localparam int ST_COIN_BIT = 3;
  localparam int ST_ON_BIT = 4;
  localparam int ST_W = 5;
  localparam logic [DAT_W-1:0] CFG_RST = 8'h08;
  localparam logic [SP_W-1:0] NRM_RST = 7'h20;
  localparam logic [SP_W-1:0] STB_RST = 7'h18;
  localparam logic [SP_W-1:0] SLP_RST = 7'h10;
  localparam logic [CFG_SLOT_W-1:0] SEQ_MAX = 3'h7;

  typedef enum logic [1:0] {SW_OFF = 2'h0, SW_PFM = 2'h1, SW_APS = 2'h2, SW_PWM = 2'h3} bmsc_sw_type;

  typedef enum logic [4:0] {
    PS_OFF = 5'h01, PS_COIN = 5'h02, PS_ON = 5'h04, PS_STBY = 5'h08, PS_SLEEP = 5'h10
  } bmsc_pstate_type;

  typedef enum logic [5:0] {
    SS_IDLE = 6'h01, SS_PFM = 6'h02, SS_APS = 6'h04, SS_PWM = 6'h08, SS_SETTLE = 6'h10, SS_RUN = 6'h20
  } bmsc_ss_type;

  typedef struct packed {
    logic enable;
    logic discharge;
    logic limit;
    bmsc_sw_type mode;
    logic [SP_W-1:0] setpoint;
  } bmsc_stage_type;

  typedef struct packed {
    bmsc_sw_type nrm;
    bmsc_sw_type stb;
  } bmsc_pair_type;

  function automatic bmsc_pair_type bmsc_decode(input logic [CFG_MODE_W-1:0] code);
    bmsc_pair_type p;
    p = '{SW_OFF, SW_OFF};
    case (code)
      4'h1: p = '{SW_PWM, SW_OFF};
      4'h3: p = '{SW_PFM, SW_OFF};
      4'h4: p = '{SW_APS, SW_OFF};
      4'h5: p = '{SW_PWM, SW_PWM};
      4'h6: p = '{SW_PWM, SW_APS};
      4'h8: p = '{SW_APS, SW_APS};
      4'hC: p = '{SW_APS, SW_PFM};
      4'hD: p = '{SW_PWM, SW_PFM};
      default: p = '{SW_OFF, SW_OFF};
    endcase
    return p;
  endfunction : bmsc_decode
endpackage : bmsc_pkg

/* core/bmsc_timer.sv */
`timescale 1ns/100ps
module bmsc_timer import bmsc_pkg::*; #(
  parameter int CYCLES = 4
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Control.
  input wire logic run_in,
  output logic done_out
);
  localparam int W = $clog2(CYCLES + 2);

  logic [W-1:0] cnt_q;
  wire logic hit = cnt_q == W'(CYCLES);
  wire logic sat = cnt_q == W'(CYCLES + 1);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !run_in) begin
      cnt_q <= '0;
    end else if (!sat) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done_out = run_in && hit;
endmodule : bmsc_timer

/* test/bmsc_top_asserts.sv */
`timescale 1ns/100ps
module bmsc_top_asserts import bmsc_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Host pins and monitors.
  input wire logic standby_in,
  input wire logic power_button_input_in,
  input wire logic main_supply_low_in,
  input wire logic [NUM_BUCK-1:0] overcurrent_in,
  // Stage outputs.
  input wire bmsc_stage_type [NUM_BUCK-1:0] stage_out,
  input wire bmsc_pstate_type pstate_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_coin;
    (pstate_out == PS_COIN) [*3];
  endsequence
  sequence s_sleep;
    (pstate_out == PS_SLEEP) [*3];
  endsequence
  property p_coin;
    $rose(main_supply_low_in) |-> ##[1:6] pstate_out == PS_COIN;
  endproperty
  a_coin: assert property (p_coin) else $error("Supply loss did not reach coin cell.");
  property p_coin_off;
    s_coin |-> (stage_out[0].enable | stage_out[1].enable | stage_out[2].enable) == 1'b0;
  endproperty
  a_coin_off: assert property (p_coin_off) else $error("A buck runs in coin cell.");
  property p_stby;
    $rose(standby_in) && pstate_out == PS_ON && power_button_input_in |-> ##[2:6] pstate_out == PS_STBY;
  endproperty
  a_stby: assert property (p_stby) else $error("Standby pin did not enter standby.");
  property p_wake;
    $fell(standby_in) && pstate_out == PS_STBY && power_button_input_in |-> ##[2:6] pstate_out == PS_ON;
  endproperty
  a_wake: assert property (p_wake) else $error("Standby release did not return to on.");
  property p_turnoff;
    $fell(power_button_input_in) && pstate_out inside {PS_ON, PS_STBY} |->
      ##[2:6] pstate_out inside {PS_SLEEP, PS_OFF};
  endproperty
  a_turnoff: assert property (p_turnoff) else $error("Button low did not turn off.");
  for (genvar k = 0; k < NUM_BUCK; k++) begin : g_buck
    property p_off;
      (stage_out[k].mode == SW_OFF) == !stage_out[k].enable && stage_out[k].discharge == !stage_out[k].enable;
    endproperty
    a_off: assert property (p_off) else $error("Off mode and discharge disagree.");
    property p_step;
      stage_out[k].enable && $past(stage_out[k].enable) && $changed(stage_out[k].setpoint) |->
        (stage_out[k].setpoint == $past(stage_out[k].setpoint) + 7'h01 ||
        stage_out[k].setpoint + 7'h01 == $past(stage_out[k].setpoint)) ##1 $stable(stage_out[k].setpoint);
    endproperty
    a_step: assert property (p_step) else $error("Set point jumped.");
    property p_limit;
      (overcurrent_in[k] && stage_out[k].enable) [*4] |-> stage_out[k].limit;
    endproperty
    a_limit: assert property (p_limit) else $error("Current limit not applied.");
    property p_sleep;
      s_sleep ##0 stage_out[k].enable |-> stage_out[k].mode == SW_PFM;
    endproperty
    a_sleep: assert property (p_sleep) else $error("Kept buck not in PFM in sleep.");
  end
endmodule : bmsc_top_asserts

/* test/bmsc_stage_model.sv */
`timescale 1ns/100ps
module bmsc_stage_model import bmsc_pkg::*; #(
  parameter int RAMP_CYC = 6
) (
  // Clock.
  input wire logic clk_sys_in,
  // Stage side.
  input wire bmsc_stage_type [NUM_BUCK-1:0] stage_in,
  input wire logic [NUM_BUCK-1:0] oc_cmd_in,
  output logic [NUM_BUCK-1:0] overcurrent_out,
  output logic [NUM_BUCK-1:0] in_regulation_out
);
  int ramp_q [NUM_BUCK];
  // The output ramps into regulation only while the stage switches.
  always_ff @(posedge clk_sys_in) begin
    for (int k = 0; k < NUM_BUCK; k++) begin
      ramp_q[k] <= !stage_in[k].enable ? 0 : (ramp_q[k] < RAMP_CYC) ? ramp_q[k] + 1 : ramp_q[k];
    end
  end
  // A stopped stage cannot overload, and it drops out of regulation one cycle after it stops.
  always_comb begin
    for (int k = 0; k < NUM_BUCK; k++) begin
      overcurrent_out[k] = oc_cmd_in[k] & stage_in[k].enable;
      in_regulation_out[k] = ramp_q[k] >= RAMP_CYC;
    end
  end
endmodule : bmsc_stage_model

/* test/tb_bmsc_top.sv */
`timescale 1ns/100ps
module tb_bmsc_top import bmsc_pkg::*;;
  localparam logic [31:0] NRM_TAB = 32'h0E023E4C;
  localparam logic [31:0] STB_TAB = 32'h05022C00;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [ADR_W-1:0] reg_addr_in = 5'h00;
  logic [DAT_W-1:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic standby_in = 1'b0;
  logic power_button_input_in = 1'b0;
  logic main_supply_low_in = 1'b0;
  logic [NUM_BUCK-1:0] oc_cmd = 3'h0;
  logic [NUM_BUCK-1:0] overcurrent_in;
  logic [NUM_BUCK-1:0] in_regulation_in;
  logic [DAT_W-1:0] reg_rdata_out;
  bmsc_stage_type [NUM_BUCK-1:0] stage_out;
  bmsc_pstate_type pstate_out;
  logic irq_out;
  int mismatches = 0;
  int check_count = 0;
  int cnt;
  bmsc_top #(.OCP_CYC(20), .SETTLE_CYC(10), .SLOT_CYC(8), .DVS_CYC(4)) bmsc_top_inst (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .standby_in(standby_in), .power_button_input_in(power_button_input_in),
    .main_supply_low_in(main_supply_low_in), .overcurrent_in(overcurrent_in),
    .in_regulation_in(in_regulation_in), .stage_out(stage_out), .pstate_out(pstate_out), .irq_out(irq_out));
  bmsc_stage_model bmsc_stage_model_inst (.clk_sys_in(clk_sys_in), .stage_in(stage_out),
    .oc_cmd_in(oc_cmd), .overcurrent_out(overcurrent_in), .in_regulation_out(in_regulation_in));
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic hang();
    mismatches++;
    conclude();
  endtask : hang
  task automatic check(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : wt
  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wr
  task automatic rdc(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] m, input logic [DAT_W-1:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out & m, e);
    @(posedge clk_sys_in);
  endtask : rdc
  task automatic wait_ps(input bmsc_pstate_type ps);
    for (cnt = 0; cnt < 50 && pstate_out !== ps; cnt++) @(posedge clk_sys_in);
    if (cnt == 50) hang();
  endtask : wait_ps
  task automatic wchg(input int k, input bmsc_sw_type e);
    bmsc_sw_type m0;
    m0 = stage_out[k].mode;
    for (cnt = 0; cnt < 300 && stage_out[k].mode === m0; cnt++) @(posedge clk_sys_in);
    if (cnt == 300) hang();
    check(8'(stage_out[k].mode), 8'(e));
  endtask : wchg
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    wr(A_PSTATE, 8'hFF);
    wr(5'h16, 8'hFF);
    rdc(A_PSTATE, 8'hFF, 8'h01);
    rdc(5'h16, 8'hFF, 8'h00);
    for (int k = 0; k < NUM_BUCK; k++) begin
      rdc(A_CFG + 5'(k), 8'hFF, CFG_RST);
    end
    rdc(A_NRM, 8'hFF, 8'h20);
    rdc(A_STB, 8'hFF, 8'h18);
    rdc(A_SLP, 8'hFF, 8'h10);
    $display("Reset values done");
    wr(A_MASK, 8'h1F);
    power_button_input_in <= 1'b1;
    wait_ps(PS_ON);
    wt(10);
    rdc(A_STATUS, 8'hFF, 8'h10);
    check(8'(irq_out), 8'h01);
    wr(A_STATUS, 8'h10);
    wt(1);
    check(8'(irq_out), 8'h00);
    wt(200);
    for (int k = 0; k < NUM_BUCK; k++) begin
      rdc(A_LIVE + 5'(k), 8'h0F, 8'h06);
    end
    $display("Turn-on done");
    for (int c = 0; c < 16; c++) begin
      wr(A_CFG, 8'(c));
      wt(100);
      rdc(A_LIVE, 8'h03, 8'(NRM_TAB[2*c +: 2]));
      standby_in <= 1'b1;
      wt(100);
      rdc(A_PSTATE, 8'hFF, 8'h08);
      rdc(A_LIVE, 8'h03, 8'(STB_TAB[2*c +: 2]));
      rdc(A_CUR, 8'hFF, 8'h18);
      standby_in <= 1'b0;
      wt(100);
      rdc(A_LIVE, 8'h03, 8'(NRM_TAB[2*c +: 2]));
      rdc(A_CUR, 8'hFF, 8'h20);
    end
    $display("Mode codes done");
    wr(A_CFG, 8'h18);
    wr(A_CFG + 5'h01, 8'h45);
    wr(A_CFG + 5'h02, 8'h18);
    wr(A_NRM + 5'h01, 8'h30);
    wt(100);
    oc_cmd <= 3'h4;
    wt(15);
    oc_cmd <= 3'h0;
    wt(5);
    rdc(A_STATUS, 8'hFF, 8'h00);
    oc_cmd <= 3'h4;
    wt(30);
    rdc(A_LIVE + 5'h02, 8'h10, 8'h10);
    rdc(A_STATUS, 8'hFF, 8'h04);
    check(8'(irq_out), 8'h01);
    oc_cmd <= 3'h0;
    wr(A_STATUS, 8'h04);
    rdc(A_STATUS, 8'hFF, 8'h00);
    $display("Overcurrent done");
    power_button_input_in <= 1'b0;
    wait_ps(PS_SLEEP);
    wt(100);
    rdc(A_LIVE, 8'h0F, 8'h05);
    rdc(A_LIVE + 5'h01, 8'h0F, 8'h08);
    rdc(A_CUR, 8'hFF, 8'h10);
    wr(A_SLP, 8'h7F);
    rdc(A_SLP, 8'hFF, 8'h3F);
    wr(A_SLP + 5'h01, 8'h7F);
    rdc(A_SLP + 5'h01, 8'hFF, 8'h7F);
    $display("Sleep done");
    power_button_input_in <= 1'b1;
    wait_ps(PS_ON);
    check(8'(stage_out[1].enable), 8'h00);
    check(8'(stage_out[0].enable), 8'h01);
    rdc(A_CFG + 5'h01, 8'hFF, 8'h48);
    rdc(A_NRM + 5'h01, 8'hFF, 8'h20);
    wchg(1, SW_PFM);
    wchg(1, SW_APS);
    wchg(1, SW_PWM);
    wchg(1, SW_APS);
    check(8'(cnt > 10), 8'h01);
    $display("Wake done");
    main_supply_low_in <= 1'b1;
    wait_ps(PS_COIN);
    rdc(A_STATUS, 8'h08, 8'h08);
    rdc(A_LIVE, 8'h04, 8'h00);
    main_supply_low_in <= 1'b0;
    wait_ps(PS_OFF);
    $display("Coin cell done");
    wr(A_CTRL, 8'h01);
    main_supply_low_in <= 1'b1;
    wait_ps(PS_COIN);
    main_supply_low_in <= 1'b0;
    wait_ps(PS_OFF);
    wr(A_STATUS, 8'h1F);
    wt(10);
    rdc(A_PSTATE, 8'hFF, 8'h01);
    rdc(A_STATUS, 8'h10, 8'h00);
    power_button_input_in <= 1'b0;
    wait_ps(PS_ON);
    wt(2);
    rdc(A_STATUS, 8'h10, 8'h10);
    $display("Edge style done");
    conclude();
  end
endmodule : tb_bmsc_top
bind bmsc_top bmsc_top_asserts bmsc_top_asserts_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .standby_in(standby_in), .power_button_input_in(power_button_input_in), .main_supply_low_in(main_supply_low_in),
  .overcurrent_in(overcurrent_in), .stage_out(stage_out), .pstate_out(pstate_out));
